// [common/pflhst_pkg.sv]
package pflhst_pkg;

   // bus geometry
   localparam int ADDR_W = 18;
   localparam int DATA_W = 16;

   // timing, in ns, and cycle counts at the 100 ns clock
   localparam int CLK_NS         = 100;
   localparam int ACC_NS         = 90;
   localparam int SLEEP_EXTRA_NS = 30;
   localparam int SETUP_NS       = 100;
   localparam int READ_CYC  = (ACC_NS + CLK_NS - 1) / CLK_NS + 1;
   localparam int STROBE_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
   localparam int SLEEP_CYC =
      (ACC_NS + SLEEP_EXTRA_NS + CLK_NS - 1) / CLK_NS;
   localparam int CNT_W = 4;
   localparam logic [CNT_W-1:0] READ_CNT   = CNT_W'(READ_CYC);
   localparam logic [CNT_W-1:0] STROBE_CNT = CNT_W'(STROBE_CYC);
   localparam logic [CNT_W-1:0] CNT_ZERO   = 4'h0;

   // autoselect address fields
   localparam int AS_A0  = 0;
   localparam int AS_A1  = 1;
   localparam int AS_A6  = 6;
   localparam int AS_SEL = 8;
   localparam int SA_LSB = 12;

   // command data values
   localparam logic [7:0] CMD_RESET = 8'hf0;
   localparam logic [7:0] PROT_ON   = 8'h01;
   localparam logic [7:0] PROT_OFF  = 8'h00;

   // arbitrary continuation marker value, not tied to any maker
   localparam logic [7:0] CONT_CODE_DEFAULT = 8'h5a;

   typedef enum logic [1:0] {
      OP_READ  = 2'h0,
      OP_WRITE = 2'h1,
      OP_RESET = 2'h2,
      OP_PROT  = 2'h3
   } pflhst_op_t;

   typedef struct packed {
      pflhst_op_t          op;
      logic                byte_mode;
      logic                hv_id;
      logic [ADDR_W-1:0]   addr;
      logic [DATA_W-1:0]   data;
   } pflhst_req_t;

   // pins toward the flash
   typedef struct packed {
      logic                chip_select_n;
      logic                output_drive_n;
      logic                write_strobe_n;
      logic                width_select_n;
      logic                hw_reset_n;
      logic                reset_hv;
      logic                id_hv;
      logic [ADDR_W-1:0]   addr;
   } pflhst_pins_t;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_SETUP = 3'b001,
      ST_PULSE = 3'b011,
      ST_HOLD  = 3'b010,
      ST_DONE  = 3'b110
   } pflhst_state_t;

endpackage

// [verilog/pflhst_ctrl.sv]
// Behaviour
// R1 - byte select high gives sixteen-bit data
// R2 - byte select low: eight bits, top line addresses
// R3 - chip select high: device outputs float
// R4 - device reads array after power-up
// R5 - device reads array after algorithm ends
// R6 - suspended sector reads return status
// R7 - host issues reset after timeout or autoselect
// R8 - output drive high: device outputs float
// R9 - autoselect codes by low address bits
// R10 - identifier reread with select line high
// R11 - high voltage only for hardware autoselect
// R12 - sector address on top lines for verify
// R13 - write: chip select, strobe low, drive high
// R14 - address latched on later falling edge
// R15 - data latched on earlier rising edge
// R16 - write data width follows byte mode
// R17 - completion via ready pin and polling bits
// R18 - protected sector refuses program and erase
// R19 - reset pin high voltage unprotects temporarily
// R20 - protect other sectors before unprotecting
// R21 - stable address puts device to sleep
// R22 - bad sequence returns device to array read
// R23 - all strobes low counts as read
// R24 - reset low aborts and floats outputs
`timescale 1ns/100ps
`default_nettype none
module pflhst_ctrl
   import pflhst_pkg::*;
(
   // clock, reset, enable
   input  wire logic                I_CLK,
   input  wire logic                I_RST,
   input  wire logic                I_CE,
   // user request
   input  wire logic                I_REQ_VALID,
   input  wire pflhst_req_t         I_REQ,
   input  wire logic                I_UNPROTECT,
   output logic                     O_REQ_READY,
   output logic                     O_RSP_VALID,
   output logic [DATA_W-1:0]        O_RSP_DATA,
   output logic                     O_BUSY,
   output logic                     O_TIMEOUT,
   output logic                     O_CONT_SEEN,
   // flash pins
   output pflhst_pins_t             O_PINS,
   input  wire logic [DATA_W-1:0]   I_DQ,
   output logic [DATA_W-1:0]        O_DQ,
   output logic [DATA_W-1:0]        O_DQ_OE,
   input  wire logic                I_READY_BUSY_N
);

   pflhst_state_t       state;
   pflhst_state_t       next_state;
   pflhst_req_t         req;
   logic [CNT_W-1:0]    cnt;
   logic [CNT_W-1:0]    next_cnt;
   logic                cs_n;
   logic                oe_n;
   logic                we_n;
   logic                drive;
   logic                rsp_valid;
   logic [DATA_W-1:0]   rsp_data;
   logic                rdy_q;
   logic                timeout;
   logic                cont_seen;

   wire is_read  = (req.op == OP_READ) || (req.op == OP_PROT);
   wire is_write = (req.op == OP_WRITE) || (req.op == OP_RESET);
   wire cnt_done = (cnt == CNT_ZERO);
   wire take     = I_REQ_VALID && (state == ST_IDLE);
   // phase decodes shared by strobes and sampling
   wire in_cycle = next_state inside {ST_SETUP, ST_PULSE, ST_HOLD};
   wire in_pulse = (next_state == ST_PULSE) && !take;
   wire rd_end   = (state == ST_PULSE) && cnt_done && is_read;

   // byte mode: only low lane carries data, top line is the lsb address
   function automatic logic [DATA_W-1:0] lane_mask(input logic bm);
      lane_mask = bm ? 16'h00ff : 16'hffff;
   endfunction

   // protect verify address: sector on top lines, a1 high, a0/a6 low
   function automatic logic [ADDR_W-1:0] prot_addr(
      input logic [ADDR_W-1:0] a);
      logic [ADDR_W-1:0] r;
      r = a & {{(ADDR_W-SA_LSB){1'b1}}, {SA_LSB{1'b0}}};
      r[AS_A1] = 1'b1;
      r[AS_SEL] = a[AS_SEL];
      prot_addr = r;
   endfunction

   wire [DATA_W-1:0] rd_sample = I_DQ & lane_mask(req.byte_mode);
   wire [DATA_W-1:0] wr_data   = (req.op == OP_RESET)
                                 ? {8'h00, CMD_RESET} : req.data;
   wire id_read = req.hv_id && (req.addr[AS_A1:AS_A0] == 2'b00)
                  && !req.addr[AS_A6];

   always_comb begin
      next_state = state;
      next_cnt   = cnt;
      unique case (state)
         ST_IDLE: if (I_REQ_VALID) begin
            next_state = ST_SETUP;
            next_cnt   = STROBE_CNT;
         end
         ST_SETUP: if (cnt_done) begin
            next_state = ST_PULSE;
            next_cnt   = is_read ? READ_CNT : STROBE_CNT;
         end else begin
            next_cnt = cnt - 4'h1;
         end
         ST_PULSE: if (cnt_done) begin
            next_state = ST_HOLD;
            next_cnt   = STROBE_CNT;
         end else begin
            next_cnt = cnt - 4'h1;
         end
         ST_HOLD: if (cnt_done) begin
            next_state = ST_DONE;
         end else begin
            next_cnt = cnt - 4'h1;
         end
         ST_DONE: next_state = ST_IDLE;
         default: begin
            next_state = ST_IDLE;
            next_cnt   = CNT_ZERO;
         end
      endcase
   end

   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         state <= ST_IDLE;
         cnt   <= CNT_ZERO;
         req   <= '0;
      end else if (I_CE) begin
         state <= next_state;
         cnt   <= next_cnt;
         if (take) begin
            req <= I_REQ;
         end
      end
   end

   // strobes: chip select over the whole cycle, strobe pulse in middle
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         cs_n  <= 1'b1;
         oe_n  <= 1'b1;
         we_n  <= 1'b1;
         drive <= 1'b0;
      end else if (I_CE) begin
         cs_n  <= !in_cycle;
         // write strobe falls after chip select, address is stable [R14]
         // output drive stays high during writes [R13] [R23]
         we_n  <= !(is_write && in_pulse);
         oe_n  <= !(is_read && in_pulse);
         // data held past strobe rise so it latches cleanly [R15] [R16]
         drive <= is_write && !take
                  && in_cycle;
      end
   end

   // sample at end of read strobe; note continuation marker [R10]
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         rsp_valid <= 1'b0;
         rsp_data  <= '0;
         cont_seen <= 1'b0;
      end else if (I_CE) begin
         rsp_valid <= (state == ST_DONE);
         if (rd_end) begin
            rsp_data  <= rd_sample;
            cont_seen <= id_read && !req.addr[AS_SEL]
                         && (rd_sample[7:0] == CONT_CODE_DEFAULT);
         end
      end
   end

   // completion and timeout flags from ready pin and status bits
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         rdy_q   <= 1'b1;
         timeout <= 1'b0;
      end else if (I_CE) begin
         rdy_q <= I_READY_BUSY_N;                               // [R17]
         if (rd_end && rd_sample[5]
             && rd_sample[6] != rsp_data[6]) begin
            timeout <= 1'b1;                                   // [R7]
         end else if (req.op == OP_RESET && state == ST_DONE) begin
            timeout <= 1'b0;
         end
      end
   end

   assign O_REQ_READY = (state == ST_IDLE);
   assign O_RSP_VALID = rsp_valid;
   assign O_RSP_DATA  = rsp_data;
   assign O_BUSY      = !rdy_q;
   assign O_TIMEOUT   = timeout;
   assign O_CONT_SEEN = cont_seen;

   assign O_PINS.chip_select_n  = cs_n;                         // [R3]
   assign O_PINS.output_drive_n = oe_n;                         // [R8]
   assign O_PINS.write_strobe_n = we_n;
   assign O_PINS.width_select_n = !req.byte_mode;          // [R1] [R2]
   assign O_PINS.hw_reset_n     = 1'b1;                         // [R24]
   assign O_PINS.reset_hv       = I_UNPROTECT;            // [R19] [R20]
   assign O_PINS.id_hv          = req.hv_id;                   // [R11]
   assign O_PINS.addr = (req.op == OP_PROT) ? prot_addr(req.addr)
                        : req.addr;                      // [R9] [R12]

   // byte mode: top line carries the lsb address bit [R2]
   assign O_DQ    = req.byte_mode
                    ? {req.data[DATA_W-1], 7'h00, wr_data[7:0]}
                    : wr_data;
   assign O_DQ_OE = req.byte_mode
                    ? {cs_n ? 1'b0 : 1'b1, 7'h00, {8{drive}}}
                    : {DATA_W{drive}};

endmodule
`default_nettype wire

// [tb/pflhst_asserts.sv]
`timescale 1ns/100ps
`default_nettype none
module pflhst_asserts
   import pflhst_pkg::*;
(
   // watched ports
   input wire logic              I_CLK,
   input wire logic              I_RST,
   input wire logic              I_CE,
   input wire logic              I_REQ_VALID,
   input wire pflhst_req_t       I_REQ,
   input wire logic              O_REQ_READY,
   input wire pflhst_pins_t      O_PINS,
   input wire logic [DATA_W-1:0] O_DQ,
   input wire logic [DATA_W-1:0] O_DQ_OE
);
   pflhst_req_t      rq;
   wire logic        cs = !O_PINS.chip_select_n;
   wire logic        ws = !O_PINS.write_strobe_n;
   wire logic [17:0] pa = {rq.addr[17:12], 3'h0, rq.addr[8], 8'h02};
   // request of the transfer under way
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST)
         rq <= '0;
      else if (I_CE && I_REQ_VALID && O_REQ_READY)
         rq <= I_REQ;
   end
   default clocking dc @(posedge I_CLK); endclocking
   default disable iff (I_RST);
   sequence wr_pulse;
      ws ##1 ws ##1 !ws;
   endsequence
   chk_write_qual: assert property (
      ws |-> cs && O_PINS.output_drive_n) else $error("bad write");
   chk_strobe_len: assert property (
      $rose(ws) |-> wr_pulse) else $error("strobe length");
   chk_no_fight: assert property (
      !O_PINS.output_drive_n |-> O_DQ_OE[14:0] == 15'h0)
      else $error("host drives in read");
   chk_wr_data: assert property (
      ws |-> O_DQ[7:0] == (rq.op == OP_RESET ? CMD_RESET : rq.data[7:0])
      && O_DQ_OE[7:0] == 8'hff) else $error("write low byte");
   chk_word_lanes: assert property (
      ws && O_PINS.width_select_n |-> O_DQ_OE == 16'hffff
      && O_DQ == (rq.op == OP_RESET ? {8'h00, CMD_RESET} : rq.data))
      else $error("write word");
   chk_byte_lanes: assert property (
      cs && !O_PINS.width_select_n |-> O_DQ_OE[14:8] == 7'h00)
      else $error("byte lanes driven");
   chk_verify_addr: assert property (
      cs && rq.op == OP_PROT |-> O_PINS.addr == pa)
      else $error("verify address");
   chk_reset_cmd: assert property (
      ws && rq.op == OP_RESET |-> O_DQ[7:0] == CMD_RESET)
      else $error("reset command");
endmodule
bind pflhst_ctrl pflhst_asserts chk_u (
   .I_CLK(I_CLK), .I_RST(I_RST), .I_CE(I_CE),
   .I_REQ_VALID(I_REQ_VALID), .I_REQ(I_REQ),
   .O_REQ_READY(O_REQ_READY), .O_PINS(O_PINS),
   .O_DQ(O_DQ), .O_DQ_OE(O_DQ_OE));
`default_nettype wire

// [tb/pflhst_flash_model.sv]
`timescale 1ns/100ps
`default_nettype none
module pflhst_flash_model
   import pflhst_pkg::*;
#(
   parameter logic [7:0] MFR_CODE = 8'h3c,
   parameter logic [7:0] DEV_CODE = 8'h6e
)(
   // pins
   input  wire pflhst_pins_t      i_pins,
   input  wire logic [DATA_W-1:0] i_dq,
   output logic [DATA_W-1:0]      o_dq,
   output logic                   o_ready_busy_n
);
   // suspend and resume command values, status word of a suspended sector
   localparam logic [7:0]  SUSP_CMD   = 8'hb0;
   localparam logic [7:0]  RESUME_CMD = 8'h30;
   localparam logic [15:0] SUSP_STAT  = 16'h0080;
   logic [15:0] mem [16];
   logic [15:0] val, m;
   logic [3:0]  wa;
   logic [5:0]  wsec, ssec;
   logic        act, lp, sus;
   wire logic        cs = !i_pins.chip_select_n;
   wire logic        byt = !i_pins.width_select_n;
   wire logic        hp = i_pins.addr[17];
   wire logic [15:0] w = mem[i_pins.addr[3:0]];
   wire logic [7:0]  lo = byt && i_dq[15] ? w[15:8] : w[7:0];
   // read outputs
   wire logic rd = cs && !i_pins.output_drive_n && i_pins.hw_reset_n;
   always_comb begin
      val = byt ? {8'h0, lo} : w;
      if (i_pins.id_hv) begin
         val = {8'h0, i_pins.addr[8] ? MFR_CODE : CONT_CODE_DEFAULT};
         if (i_pins.addr[0])
            val[7:0] = DEV_CODE;
         if (i_pins.addr[1])
            val = {15'h0, hp};
      end
      if (sus && !i_pins.id_hv && i_pins.addr[17:12] == ssec)
         val = SUSP_STAT;
      m = !rd ? 16'h0 : byt ? 16'h00ff : 16'hffff;
   end
   // released lines show the inverse
   assign o_dq = ~(val ^ m);
   initial begin
      o_ready_busy_n = 1'b1;
      act = 1'b0;
      sus = 1'b0;
      for (int i = 0; i < 16; i++)
         mem[i] = 16'ha500 + 16'(i);
   end
   always @(negedge i_pins.chip_select_n
            or negedge i_pins.write_strobe_n) begin
      if (!i_pins.chip_select_n && !i_pins.write_strobe_n
          && i_pins.output_drive_n) begin
         wa = i_pins.addr[3:0];
         wsec = i_pins.addr[17:12];
         lp = hp && !i_pins.reset_hv;
         act = 1'b1;
      end
   end
   always @(posedge i_pins.chip_select_n
            or posedge i_pins.write_strobe_n) begin
      if (act) begin
         act = 1'b0;
         if (i_dq[7:0] == SUSP_CMD) begin
            sus = 1'b1;
            ssec = wsec;
         end else if (i_dq[7:0] == RESUME_CMD
                      || i_dq[7:0] == CMD_RESET) begin
            sus = 1'b0;
         end else if (!lp) begin
            mem[wa] = i_dq;
            o_ready_busy_n = 1'b0;
            #400 o_ready_busy_n = 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// [tb/testbench.sv]
`timescale 1ns/100ps
`default_nettype none
module testbench
   import pflhst_pkg::*;
;
   localparam logic [7:0] MFR = 8'h3c; // arbitrary value
   localparam logic [7:0] DEV = 8'h6e; // arbitrary value
   logic              clk, rst, valid, unprot, rdy, rv, busy, tmo, cont, rb_n;
   pflhst_req_t       req;
   pflhst_pins_t      pins;
   logic [DATA_W-1:0] rdat, hq, hoe, mq, dq, r;
   int                fail_count, num_checks;
   always #50 clk = ~clk;
   assign dq = (hq & hoe) | (mq & ~hoe);
   pflhst_ctrl dut_u (.I_CLK(clk), .I_RST(rst), .I_CE(1'b1),
      .I_REQ_VALID(valid), .I_REQ(req), .I_UNPROTECT(unprot),
      .O_REQ_READY(rdy), .O_RSP_VALID(rv), .O_RSP_DATA(rdat),
      .O_BUSY(busy), .O_TIMEOUT(tmo), .O_CONT_SEEN(cont), .O_PINS(pins),
      .I_DQ(dq), .O_DQ(hq), .O_DQ_OE(hoe), .I_READY_BUSY_N(rb_n));
   pflhst_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) dev_u (
      .i_pins(pins), .i_dq(dq), .o_dq(mq), .o_ready_busy_n(rb_n));
   task results;
      $display("checks %0d errors %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task chk(input logic [15:0] g, e);
      num_checks++;
      if (g !== e) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task xf(input pflhst_op_t o, input logic b, h, input logic [17:0] a,
           input logic [15:0] d, output logic [15:0] q);
      int n;
      @(negedge clk);
      req = '{o, b, h, a, d};
      valid = 1;
      @(negedge clk);
      valid = 0;
      chk({15'h0, rdy}, 16'h0);
      n = 0;
      while (rv !== 1'b1 && n < 20) begin
         @(negedge clk);
         n++;
      end
      if (n == 20) begin
         fail_count++;
         results();
      end
      q = rdat;
   endtask
   task t_word;
      xf(OP_READ, 0, 0, 18'h3, 0, r);
      chk(r, 16'ha503);
      xf(OP_WRITE, 0, 0, 18'h5, 16'h1234, r);
      chk({15'h0, busy}, 16'h1);
      xf(OP_READ, 0, 0, 18'h5, 0, r);
      chk(r, 16'h1234);
      chk({15'h0, busy}, 16'h0);
   endtask
   task t_susp;
      xf(OP_WRITE, 0, 0, 18'h08000, 16'h00b0, r);
      xf(OP_READ, 0, 0, 18'h08004, 0, r);
      chk(r, 16'h0080);
      xf(OP_READ, 0, 0, 18'h4, 0, r);
      chk(r, 16'ha504);
      xf(OP_WRITE, 0, 0, 18'h08000, 16'h0030, r);
      xf(OP_READ, 0, 0, 18'h08004, 0, r);
      chk(r, 16'ha504);
   endtask
   task t_byte;
      xf(OP_READ, 1, 0, 18'h6, 16'h8000, r);
      chk(r, 16'h00a5);
      xf(OP_READ, 1, 0, 18'h6, 0, r);
      chk(r, 16'h0006);
   endtask
   task t_prot;
      xf(OP_WRITE, 0, 0, 18'h20007, 16'h7777, r);
      xf(OP_READ, 0, 0, 18'h20007, 0, r);
      chk(r, 16'ha507);
      unprot = 1;
      xf(OP_WRITE, 0, 0, 18'h20007, 16'h7777, r);
      unprot = 0;
      xf(OP_READ, 0, 0, 18'h20007, 0, r);
      chk(r, 16'h7777);
      xf(OP_WRITE, 0, 0, 18'h20007, 16'h1111, r);
      xf(OP_READ, 0, 0, 18'h20007, 0, r);
      chk(r, 16'h7777);
   endtask
   task t_auto;
      xf(OP_READ, 0, 1, 18'h0, 0, r);
      chk(r, {8'h0, CONT_CODE_DEFAULT});
      chk({15'h0, cont}, 16'h1);
      xf(OP_READ, 0, 1, 18'h100, 0, r);
      chk(r, {8'h0, MFR});
      chk({15'h0, cont}, 16'h0);
      xf(OP_READ, 0, 1, 18'h1, 0, r);
      chk(r, {8'h0, DEV});
      xf(OP_PROT, 0, 1, 18'h20000, 0, r);
      chk(r, 16'h1);
      xf(OP_PROT, 0, 1, 18'h10fff, 0, r);
      chk(r, 16'h0);
      chk({15'h0, tmo}, 16'h1);
      xf(OP_RESET, 0, 0, 18'h0, 16'h00f0, r);
      chk({15'h0, tmo}, 16'h0);
   endtask
   initial begin
      clk = 0;
      rst = 1;
      valid = 0;
      unprot = 0;
      req = '0;
      fail_count = 0;
      num_checks = 0;
      repeat (8) @(posedge clk);
      @(negedge clk);
      rst = 0;
      t_word();
      t_byte();
      t_prot();
      t_susp();
      t_auto();
      results();
   end
endmodule
`default_nettype wire
